// *** rotc_calibrator.v ***
`timescale 1ns/1ps
`include "rotc_defs.vh"
module rotc_calibrator (
  // Clock and reset.
  input wire SYS_CLK,
  input wire NRST,
  // Control.
  input wire START,
  input wire [3:0] INPUT_FILTER_SETTING,
  input wire [4:0] FILTER_DIV,
  input wire [1:0] CAPTURE_EDGE_PRESCALE,
  // Reference.
  input wire REFERENCE_INPUT_PIN,
  // Results.
  output reg [2:0] OSCILLATOR_TRIM_SETTING,
  output reg BUSY,
  output reg DONE,
  output reg [31:0] PULSE_COUNT,
  output reg MEASUREMENT_DONE_STATE
);
  localparam S_IDLE = 3'h0;
  localparam S_ARM = 3'h1;
  localparam S_MEAS = 3'h2;
  localparam S_EVAL = 3'h3;
  localparam S_FIN = 3'h4;

  localparam [31:0] PERIOD_PULSES = `ROTC_PERIOD_COUNT;

  reg [2:0] state;
  reg [15:0] timer_count_value;
  reg timer_run;
  reg [15:0] capture_value_register;
  reg [15:0] start_cap;
  reg [15:0] end_cap;
  reg [15:0] overflow_tally;
  reg first_seen;
  reg [3:0] edge_cnt;
  reg [3:0] prescale_edges;
  reg [2:0] prev_trim;
  reg [31:0] prev_diff;
  reg have_prev;
  reg [31:0] count_now;
  reg [31:0] diff_now;
  wire filtered_rise;
  wire overflow_evt;
  wire end_hit;
  wire [31:0] expected_now;

  rotc_filter u_filter (
    .clk(SYS_CLK),
    .nrst(NRST),
    .din(REFERENCE_INPUT_PIN),
    .div_sel(FILTER_DIV),
    .filter_set(INPUT_FILTER_SETTING),
    .dout(),
    .rise(filtered_rise)
  );

  always @* begin
    case (CAPTURE_EDGE_PRESCALE)
      2'h0: prescale_edges = 4'h1;
      2'h1: prescale_edges = 4'h2;
      2'h2: prescale_edges = 4'h4;
      default: prescale_edges = 4'h8;
    endcase
  end

  assign overflow_evt = timer_run && (timer_count_value == 16'hffff);

  // The L-th valid rise after the start capture closes the measurement.
  assign end_hit = filtered_rise && first_seen && (edge_cnt + 4'h1 >= prescale_edges);

  // Ideal count scales with the number of periods measured; L is a power of two.
  assign expected_now = PERIOD_PULSES << CAPTURE_EDGE_PRESCALE;

  // Pulse count of a finished measurement and its distance from the target.
  always @* begin
    count_now = {16'h0000, end_cap} + {overflow_tally, 16'h0000} - {16'h0000, start_cap};
    diff_now = (count_now >= expected_now) ? count_now - expected_now : expected_now - count_now;
  end

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      state <= S_IDLE;
      timer_count_value <= 16'h0000;
      timer_run <= 1'b0;
      capture_value_register <= 16'h0000;
      start_cap <= 16'h0000;
      end_cap <= 16'h0000;
      overflow_tally <= 16'h0000;
      first_seen <= 1'b0;
      edge_cnt <= 4'h0;
      prev_trim <= `ROTC_TRIM_RESET;
      prev_diff <= 32'h00000000;
      have_prev <= 1'b0;
      OSCILLATOR_TRIM_SETTING <= `ROTC_TRIM_RESET;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      PULSE_COUNT <= 32'h00000000;
      MEASUREMENT_DONE_STATE <= 1'b0;
    end else begin
      if (timer_run) begin
        timer_count_value <= timer_count_value + 16'h0001;
      end
      case (state)
        S_IDLE: begin
          if (START) begin
            OSCILLATOR_TRIM_SETTING <= `ROTC_TRIM_HIGHEST;
            have_prev <= 1'b0;
            BUSY <= 1'b1;
            DONE <= 1'b0;
            state <= S_ARM;
          end
        end
        S_ARM: begin
          // Timer reinitialised for each trim value before measuring.
          timer_count_value <= 16'h0000;
          timer_run <= 1'b1;
          overflow_tally <= 16'h0000;
          first_seen <= 1'b0;
          edge_cnt <= 4'h0;
          MEASUREMENT_DONE_STATE <= 1'b0;
          state <= S_MEAS;
        end
        S_MEAS: begin
          // A wrap after the start capture's value counts; one after the end capture's value does not.
          if (overflow_evt && (first_seen || filtered_rise) && !end_hit) begin
            overflow_tally <= overflow_tally + 16'h0001;
          end
          if (filtered_rise && !first_seen) begin
            capture_value_register <= timer_count_value;
            start_cap <= timer_count_value;
            first_seen <= 1'b1;
          end else if (end_hit) begin
            capture_value_register <= timer_count_value;
            end_cap <= timer_count_value;
            timer_run <= 1'b0;
            MEASUREMENT_DONE_STATE <= 1'b1;
            state <= S_EVAL;
            edge_cnt <= 4'h0;
          end else if (filtered_rise) begin
            edge_cnt <= edge_cnt + 4'h1;
          end
        end
        S_EVAL: begin
          PULSE_COUNT <= count_now;
          if (have_prev && diff_now > prev_diff) begin
            OSCILLATOR_TRIM_SETTING <= prev_trim;
            state <= S_FIN;
          end else if (OSCILLATOR_TRIM_SETTING == `ROTC_TRIM_LOWEST) begin
            state <= S_FIN;
          end else begin
            prev_trim <= OSCILLATOR_TRIM_SETTING;
            prev_diff <= diff_now;
            have_prev <= 1'b1;
            OSCILLATOR_TRIM_SETTING <= OSCILLATOR_TRIM_SETTING - 3'h1;
            state <= S_ARM;
          end
        end
        S_FIN: begin
          BUSY <= 1'b0;
          DONE <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// *** rotc_defs.vh ***
`ifndef ROTC_DEFS_VH
`define ROTC_DEFS_VH
`define ROTC_NOMINAL_HZ 16000000
`define ROTC_REF_PERIOD_US 20000
`define ROTC_AVG_PERIODS 8
`define ROTC_PERIOD_COUNT (`ROTC_NOMINAL_HZ / 1000000 * `ROTC_REF_PERIOD_US)
`define ROTC_EXPECTED_COUNT (`ROTC_PERIOD_COUNT * `ROTC_AVG_PERIODS)
`define ROTC_TRIM_HIGHEST 3'h3
`define ROTC_TRIM_LOWEST 3'h4
`define ROTC_TRIM_RESET 3'h0
`define ROTC_FILTER_DEFAULT 4'h3
`define ROTC_DIV_DEFAULT 5'h00
`define ROTC_PSC_DEFAULT 2'h0
`define ROTC_WRAP 32'h00010000
`endif

// *** rotc_filter.v ***
`timescale 1ns/1ps
`include "rotc_defs.vh"
module rotc_filter (
  input wire clk,
  input wire nrst,
  input wire din,
  input wire [4:0] div_sel,
  input wire [3:0] filter_set,
  output reg dout,
  output reg rise
);
  reg [4:0] div_cnt;
  reg [7:0] run;
  reg [7:0] need;
  wire tick;

  // Setting n needs 2^n equal samples (0 = pass through), settings 7 and up need 128; 3 gives eight.
  always @* begin
    case (filter_set)
      4'h0: need = 8'h01;
      4'h1: need = 8'h02;
      4'h2: need = 8'h04;
      4'h3: need = 8'h08;
      4'h4: need = 8'h10;
      4'h5: need = 8'h20;
      4'h6: need = 8'h40;
      default: need = 8'h80;
    endcase
  end

  assign tick = (div_cnt == div_sel);

  always @(posedge clk) begin
    if (!nrst) begin
      div_cnt <= 5'h00;
      run <= 8'h00;
      dout <= 1'b0;
      rise <= 1'b0;
    end else begin
      rise <= 1'b0;
      div_cnt <= tick ? 5'h00 : div_cnt + 5'h01;
      if (tick) begin
        if (din == dout) begin
          run <= 8'h00;
        end else if (run + 8'h01 >= need) begin
          // Same run length on both edges, so delay cancels per interval.
          dout <= din;
          rise <= din;
          run <= 8'h00;
        end else begin
          run <= run + 8'h01;
        end
      end
    end
  end
endmodule

// *** rotc_calibrator_checker.sv ***
`timescale 1ns/1ps
module rotc_calibrator_checker (
  // Clock and reset.
  input wire SYS_CLK,
  input wire NRST,
  // Watched ports.
  input wire START,
  input wire [2:0] OSCILLATOR_TRIM_SETTING,
  input wire BUSY,
  input wire DONE,
  input wire [31:0] PULSE_COUNT,
  input wire MEASUREMENT_DONE_STATE
);
  wire [2:0] trim = OSCILLATOR_TRIM_SETTING;
  wire mds = MEASUREMENT_DONE_STATE;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_start_loads_highest: assert property (START && !BUSY |=> BUSY && trim == 3'h3)
    else $error("start did not load the highest trim");
  a_trim_step_one: assert property (BUSY && $past(BUSY) && trim != $past(trim)
    |-> trim == $past(trim) - 3'h1 || trim == $past(trim) + 3'h1) else $error("trim moved by more than one");
  a_trim_after_done: assert property (BUSY && $past(BUSY) && trim != $past(trim) |-> mds || $past(mds))
    else $error("trim moved without a finished measurement");
  a_count_on_done: assert property ($changed(PULSE_COUNT) |-> mds || $past(mds))
    else $error("pulse count changed outside done state");
  a_done_ends_busy: assert property ($rose(DONE) |-> !BUSY && $past(BUSY))
    else $error("done rose without ending busy");
  a_done_holds_trim: assert property (DONE && !START |=> DONE && $stable(trim))
    else $error("result trim not held");
  a_start_refused: assert property (BUSY && START && !mds |=> $stable(trim))
    else $error("start taken while busy");
  a_lowest_no_wrap: assert property (BUSY && trim == 3'h4 |=> trim == 3'h4 || trim == 3'h5)
    else $error("trim wrapped past lowest value");
  a_reset_clears: assert property (disable iff (1'b0) !NRST |=> trim == 3'h0 && !BUSY && !DONE)
    else $error("reset values wrong");
endmodule

// *** rotc_ref_model.sv ***
`timescale 1ns/1ps
module rotc_ref_model (
  // Clock.
  input wire logic clk,
  // Trim seen by the oscillator, and a reversed slope for the restore case.
  input wire logic [2:0] trim,
  input wire logic falling,
  // Reference.
  output logic ref_out = 1'b0
);
  int cnt = 0;
  int per = 1000;
  // The next period is chosen at the end of the current one, so a trim change shows one period later.
  always @(posedge clk) begin
    if (cnt >= per - 1) begin
      cnt <= 0;
      per <= falling ? 1000 + 40 * (int'($signed(trim)) + 4) : 1000 + 40 * (3 - int'($signed(trim)));
    end else begin
      cnt <= cnt + 1;
    end
    ref_out <= cnt < per / 2;
  end
endmodule

// *** test_rotc_calibrator.sv ***
`timescale 1ns/1ps
module test_rotc_calibrator;
  logic clk = 0, nrst = 0, start = 0, fall = 0;
  logic [3:0] fset = 4'h3;
  logic [4:0] fdiv = 5'h00;
  logic [1:0] psc = 2'h0;
  wire ref_in, busy, done, mds;
  wire [2:0] trim;
  wire [31:0] cnt;
  int n_errors = 0, total_checks = 0;
  initial forever #2.5 clk = ~clk;
  rotc_calibrator DUT (.SYS_CLK(clk), .NRST(nrst), .START(start), .INPUT_FILTER_SETTING(fset), .FILTER_DIV(fdiv),
    .CAPTURE_EDGE_PRESCALE(psc), .REFERENCE_INPUT_PIN(ref_in), .OSCILLATOR_TRIM_SETTING(trim), .BUSY(busy),
    .DONE(done), .PULSE_COUNT(cnt), .MEASUREMENT_DONE_STATE(mds));
  rotc_ref_model u_ref (.clk(clk), .trim(trim), .falling(fall), .ref_out(ref_in));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Starting mid-period keeps the first captured period on the new trim.
  task run_cal;
    int i;
    @(negedge ref_in);
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (100) @(posedge clk);
    start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    #1 check(32'(trim), 32'h3);
    i = 0;
    while (done !== 1'b1 && i < 40000) begin
      @(posedge clk);
      i++;
    end
    #1 check(32'(busy), 32'h0);
  endtask
  // Counts rise towards the ideal value on every step, so the search runs to the lowest trim.
  task test_reach_lowest;
    run_cal();
    check(32'(trim), 32'h4);
    check(cnt, 32'd1280);
    check(32'(mds), 32'h1);
  endtask
  // Counts fall away after the first step, so the previous trim is restored.
  task test_restore;
    @(posedge clk) begin
      fall <= 1'b1;
      psc <= 2'h1;
      fset <= 4'h4;
      fdiv <= 5'h01;
    end
    run_cal();
    check(32'(trim), 32'h3);
    check(cnt, 32'd2480);
    check(32'(done), 32'h1);
  endtask
  // Eight periods, pass-through filter at the slowest sample clock; both spans are whole multiples of 32 cycles.
  task test_restore_eight;
    @(posedge clk) begin
      psc <= 2'h3;
      fset <= 4'h0;
      fdiv <= 5'h1f;
    end
    run_cal();
    check(32'(trim), 32'h3);
    check(cnt, 32'd9920);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 check({29'h0, trim} | {busy, done, 30'h0}, 32'h0);
    test_reach_lowest();
    test_restore();
    test_restore_eight();
    final_report();
  end
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
endmodule
bind rotc_calibrator rotc_calibrator_checker u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .START(START),
  .OSCILLATOR_TRIM_SETTING(OSCILLATOR_TRIM_SETTING), .BUSY(BUSY), .DONE(DONE), .PULSE_COUNT(PULSE_COUNT),
  .MEASUREMENT_DONE_STATE(MEASUREMENT_DONE_STATE));
